// [ncs_defines.vh]
`ifndef NCS_DEFINES_VH
`define NCS_DEFINES_VH

// ***********************************
// register byte offsets
// ***********************************
`define NCS_OFS_STATUS 8'h00
`define NCS_OFS_CODE 8'h04
`define NCS_OFS_DIVIDER 8'h08
`define NCS_OFS_PROT 8'h0C
`define NCS_OFS_ADDR 8'h10
`define NCS_OFS_DATA 8'h14

// ***********************************
// status bit positions
// ***********************************
`define NCS_BIT_CBE 7
`define NCS_BIT_CCF 6
`define NCS_BIT_PVIOL 5
`define NCS_BIT_ACCERR 4
`define NCS_BIT_BLANK 2

// ***********************************
// protection register fields
// ***********************************
`define NCS_BIT_PROT_EN 16
`define NCS_PROT_BASE_RST 16'hFFFF

// ***********************************
// command codes
// ***********************************
`define NCS_CMD_BLANK 8'h05
`define NCS_CMD_BYTE_PROG 8'h20
`define NCS_CMD_BURST_PROG 8'h25
`define NCS_CMD_SECT_ERASE 8'h40
`define NCS_CMD_MASS_ERASE 8'h41
`define NCS_CMD_ERASE_ABORT 8'h47

// ***********************************
// command sequence states
// ***********************************
`define NCS_SEQ_IDLE 2'h0
`define NCS_SEQ_DATA 2'h1
`define NCS_SEQ_CODE 2'h2

// ***********************************
// misc
// ***********************************
`define NCS_SEC_UNSECURED 2'h2
`define NCS_EEPROM_TOP 16'h17FF
`define NCS_RESP_OKAY 2'h0
`define NCS_RESP_SLVERR 2'h2

`endif

// [ncs_cmd_check.v]
`timescale 1ns/1ns
`include "ncs_defines.vh"

// ***********************************
// command decode and protection check
// ***********************************
module ncs_cmd_check (
  // command under test
  input wire [7:0] code,
  input wire [15:0] addr,
  // protection setup
  input wire prot_en,
  input wire [15:0] prot_base,
  // decode results
  output reg legal,
  output reg burst,
  output reg alters,
  output reg prot_hit
);

  always @* begin
    legal = 1'b1;
    alters = 1'b0;
    case (code)
      `NCS_CMD_BLANK: alters = 1'b0;
      `NCS_CMD_BYTE_PROG: alters = 1'b1;
      `NCS_CMD_BURST_PROG: alters = 1'b1;
      `NCS_CMD_SECT_ERASE: alters = 1'b1;
      `NCS_CMD_MASS_ERASE: alters = 1'b1;
      `NCS_CMD_ERASE_ABORT: alters = 1'b0;
      default: legal = 1'b0;
    endcase
    burst = (code == `NCS_CMD_BURST_PROG);
    // mass erase touches every sector, so any protection refuses it
    prot_hit = legal && alters && prot_en &&
      ((code == `NCS_CMD_MASS_ERASE) || (addr >= prot_base));
  end

endmodule

// [ncs_nvm_command_status_unit.v]
`timescale 1ns/1ns
`include "ncs_defines.vh"

// Summary of operation
// - writing one to bit 7 launches; cleared
// - only burst program and sector erase abort commands are buffered
// - complete set when idle, cleared at launch
// - writes to complete bit are ignored
// - protected program or erase discarded, flagged
// - protection flag cleared by writing one
// - broken command sequence flags access error
// - program or erase before divider write errors
// - stop during a command flags access error
// - access error cleared by writing one
// - blank set when blank check finds erased
// - blank cleared at valid launch, writes ignored
// - codes 0x05, 0x20, 0x25 decoded
// - codes 0x40, 0x41, 0x47; others error
// - flash blank check or key unsecures
// - protected area alteration refused, mass erase too

module ncs_nvm_command_status_unit #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // axi4-lite write address
  input wire [ADDR_W-1:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  // axi4-lite write data
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  // axi4-lite write response
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready,
  // memory array side
  output reg arr_start,
  output reg [7:0] arr_code,
  output reg [15:0] arr_addr,
  output reg [7:0] arr_data,
  input wire arr_ready,
  input wire arr_done,
  input wire arr_blank,
  // system
  input wire stop_mode,
  input wire [1:0] nv_security,
  input wire backdoor_ok,
  output reg [1:0] security_state
);

  // ***********************************
  // state
  // ***********************************
  reg aw_got_reg;
  reg w_got_reg;
  reg [ADDR_W-1:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg [1:0] seq_reg;
  reg cbe_reg;
  reg ccf_reg;
  reg pviol_reg;
  reg accerr_reg;
  reg blank_reg;
  reg exec_reg;
  reg [7:0] exec_code_reg;
  reg [15:0] exec_addr_reg;
  reg [7:0] code_reg;
  reg [15:0] addr_reg;
  reg [7:0] data_reg;
  reg [7:0] pend_code_reg;
  reg [15:0] pend_addr_reg;
  reg [7:0] pend_data_reg;
  reg [7:0] div_reg;
  reg div_written_reg;
  reg prot_en_reg;
  reg [15:0] prot_base_reg;
  reg stop_prev_reg;
  reg sec_loaded_reg;

  wire cmd_legal;
  wire cmd_burst;
  wire cmd_alters;
  wire cmd_prot_hit;

  ncs_cmd_check ncs_cmd_check_i (
    .code(code_reg),
    .addr(addr_reg),
    .prot_en(prot_en_reg),
    .prot_base(prot_base_reg),
    .legal(cmd_legal),
    .burst(cmd_burst),
    .alters(cmd_alters),
    .prot_hit(cmd_prot_hit)
  );

  // ***********************************
  // write decode
  // ***********************************
  wire wr_fire = aw_got_reg && w_got_reg && !s_bvalid;
  wire wr_lane0 = wr_fire && wstrb_reg[0];
  wire wr_lanes10 = wr_fire && (wstrb_reg[1:0] == 2'h3);
  wire wr_status = wr_lane0 && (waddr_reg == `NCS_OFS_STATUS);
  wire wr_code = wr_lane0 && (waddr_reg == `NCS_OFS_CODE);
  wire wr_div = wr_lane0 && (waddr_reg == `NCS_OFS_DIVIDER);
  wire wr_prot = wr_fire && (wstrb_reg[2:0] == 3'h7) && (waddr_reg == `NCS_OFS_PROT);
  wire wr_addr = wr_lanes10 && (waddr_reg == `NCS_OFS_ADDR);
  wire wr_data = wr_lane0 && (waddr_reg == `NCS_OFS_DATA);
  wire wr_mapped = (waddr_reg == `NCS_OFS_STATUS) || (waddr_reg == `NCS_OFS_CODE) ||
    (waddr_reg == `NCS_OFS_DIVIDER) || (waddr_reg == `NCS_OFS_PROT) ||
    (waddr_reg == `NCS_OFS_ADDR) || (waddr_reg == `NCS_OFS_DATA);

  wire launch_req = wr_status && wdata_reg[`NCS_BIT_CBE] && cbe_reg;
  // a busy array only takes a following burst, or an abort of a sector erase
  wire busy_ok = !exec_reg ||
    (cmd_burst && (exec_code_reg == `NCS_CMD_BURST_PROG)) ||
    ((code_reg == `NCS_CMD_ERASE_ABORT) && (exec_code_reg == `NCS_CMD_SECT_ERASE));
  wire launch_err = (seq_reg != `NCS_SEQ_CODE) || !cmd_legal || accerr_reg ||
    pviol_reg || !busy_ok || (cmd_alters && !div_written_reg);
  wire handoff = !cbe_reg && arr_ready && !arr_start;
  wire stop_edge = stop_mode && !stop_prev_reg;

  // ***********************************
  // status image
  // ***********************************
  wire [7:0] status_img = {cbe_reg, ccf_reg, pviol_reg, accerr_reg, 1'b0,
    blank_reg, 2'h0};

  reg [31:0] rd_mux;
  reg rd_ok;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_araddr)
      `NCS_OFS_STATUS: rd_mux = {24'h00_0000, status_img};
      `NCS_OFS_CODE: rd_mux = {24'h00_0000, code_reg};
      `NCS_OFS_DIVIDER: rd_mux = {24'h00_0000, div_reg};
      `NCS_OFS_PROT: rd_mux = {15'h0000, prot_en_reg, prot_base_reg};
      `NCS_OFS_ADDR: rd_mux = {16'h0000, addr_reg};
      `NCS_OFS_DATA: rd_mux = {24'h00_0000, data_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  // ***********************************
  // axi4-lite handshakes
  // ***********************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= `NCS_RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= {ADDR_W{1'b0}};
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= `NCS_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_got_reg <= 1'b1;
        waddr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        w_got_reg <= 1'b1;
        wdata_reg <= s_wdata;
        wstrb_reg <= s_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_mapped ? `NCS_RESP_OKAY : `NCS_RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= rd_ok ? `NCS_RESP_OKAY : `NCS_RESP_SLVERR;
      end
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // ***********************************
  // command sequencing and flags
  // ***********************************
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg <= `NCS_SEQ_IDLE;
      cbe_reg <= 1'b1;
      ccf_reg <= 1'b1;
      pviol_reg <= 1'b0;
      accerr_reg <= 1'b0;
      blank_reg <= 1'b0;
      exec_reg <= 1'b0;
      exec_code_reg <= 8'h00;
      exec_addr_reg <= 16'h0000;
      code_reg <= 8'h00;
      addr_reg <= 16'h0000;
      data_reg <= 8'h00;
      pend_code_reg <= 8'h00;
      pend_addr_reg <= 16'h0000;
      pend_data_reg <= 8'h00;
      div_reg <= 8'h00;
      div_written_reg <= 1'b0;
      prot_en_reg <= 1'b0;
      prot_base_reg <= `NCS_PROT_BASE_RST;
      stop_prev_reg <= 1'b0;
      sec_loaded_reg <= 1'b0;
      security_state <= 2'h0;
      arr_start <= 1'b0;
      arr_code <= 8'h00;
      arr_addr <= 16'h0000;
      arr_data <= 8'h00;
    end else begin
      stop_prev_reg <= stop_mode;
      arr_start <= 1'b0;
      ccf_reg <= cbe_reg && !exec_reg && !arr_start;
      // flag clears first, hardware sets below win in the same cycle
      if (wr_status && wdata_reg[`NCS_BIT_PVIOL])
        pviol_reg <= 1'b0;
      if (wr_status && wdata_reg[`NCS_BIT_ACCERR])
        accerr_reg <= 1'b0;
      if (wr_div && !div_written_reg) begin
        div_reg <= wdata_reg[7:0];
        div_written_reg <= 1'b1;
      end
      // protected area may only grow
      if (wr_prot && wdata_reg[`NCS_BIT_PROT_EN] &&
          (!prot_en_reg || (wdata_reg[15:0] <= prot_base_reg))) begin
        prot_en_reg <= 1'b1;
        prot_base_reg <= wdata_reg[15:0];
      end
      if (wr_addr)
        addr_reg <= wdata_reg[15:0];
      if (wr_data) begin
        data_reg <= wdata_reg[7:0];
        if ((seq_reg != `NCS_SEQ_IDLE) || !cbe_reg) begin
          accerr_reg <= 1'b1;
          seq_reg <= `NCS_SEQ_IDLE;
        end else begin
          seq_reg <= `NCS_SEQ_DATA;
        end
      end
      if (wr_code) begin
        code_reg <= wdata_reg[7:0];
        if (seq_reg == `NCS_SEQ_DATA) begin
          seq_reg <= `NCS_SEQ_CODE;
        end else begin
          accerr_reg <= 1'b1;
          seq_reg <= `NCS_SEQ_IDLE;
        end
      end
      if (launch_req) begin
        seq_reg <= `NCS_SEQ_IDLE;
        if (launch_err) begin
          accerr_reg <= 1'b1;
        end else if (cmd_prot_hit) begin
          pviol_reg <= 1'b1;
        end else begin
          cbe_reg <= 1'b0;
          ccf_reg <= 1'b0;
          blank_reg <= 1'b0;
          pend_code_reg <= code_reg;
          pend_addr_reg <= addr_reg;
          pend_data_reg <= data_reg;
        end
      end
      if (stop_edge && (exec_reg || !cbe_reg))
        accerr_reg <= 1'b1;
      if (arr_done) begin
        exec_reg <= 1'b0;
        if ((exec_code_reg == `NCS_CMD_BLANK) && arr_blank) begin
          blank_reg <= 1'b1;
          if (exec_addr_reg > `NCS_EEPROM_TOP)
            security_state <= `NCS_SEC_UNSECURED;
        end
      end
      if (handoff) begin
        cbe_reg <= 1'b1;
        exec_reg <= 1'b1;
        exec_code_reg <= pend_code_reg;
        exec_addr_reg <= pend_addr_reg;
        arr_start <= 1'b1;
        arr_code <= pend_code_reg;
        arr_addr <= pend_addr_reg;
        arr_data <= pend_data_reg;
      end
      if (backdoor_ok)
        security_state <= `NCS_SEC_UNSECURED;
      if (!sec_loaded_reg) begin
        sec_loaded_reg <= 1'b1;
        security_state <= nv_security;
      end
    end
  end

endmodule

// [ncs_nvm_command_status_unit_properties.sv]
`timescale 1ns/1ns
`include "ncs_defines.vh"

// *****
// bus, handoff and security checks
// *****
module ncs_unit_checker #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // register bus
  input wire s_awvalid,
  input wire s_awready,
  input wire s_wvalid,
  input wire s_wready,
  input wire s_bvalid,
  input wire [ADDR_W-1:0] s_araddr,
  input wire s_arvalid,
  input wire s_arready,
  input wire [31:0] s_rdata,
  input wire [1:0] s_rresp,
  input wire s_rvalid,
  input wire s_rready,
  // array and system
  input wire arr_start,
  input wire arr_ready,
  input wire backdoor_ok,
  input wire [1:0] security_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  reg [ADDR_W-1:0] rd_addr_reg;
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      rd_addr_reg <= {ADDR_W{1'b0}};
    else if (s_arvalid && s_arready)
      rd_addr_reg <= s_araddr;
  end
  sequence wr_taken;
    s_awvalid && s_awready && s_wvalid && s_wready;
  endsequence
  sequence rd_taken;
    s_arvalid && s_arready;
  endsequence
  sequence rd_status;
    s_rvalid && rd_addr_reg == `NCS_OFS_STATUS;
  endsequence
  write_answer_a: assert property (wr_taken |=> !s_awready ##[0:1] s_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (rd_taken |=> s_rvalid && !s_arready)
    else $error("read response missing");
  read_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  unmapped_zero_a: assert property (s_rvalid && s_rresp == `NCS_RESP_SLVERR |-> s_rdata == 0)
    else $error("unmapped read not zero");
  status_spare_a: assert property (rd_status |-> (s_rdata & 32'hFFFFFF0B) == 0)
    else $error("spare status bits set");
  start_pulse_a: assert property (arr_start |=> !arr_start)
    else $error("start longer than one cycle");
  start_ready_a: assert property (arr_start |-> $past(arr_ready))
    else $error("start while array not ready");
  backdoor_unsec_a: assert property (backdoor_ok |=> security_state == `NCS_SEC_UNSECURED)
    else $error("key entry did not unsecure");
endmodule

bind ncs_nvm_command_status_unit ncs_unit_checker #(.ADDR_W(ADDR_W)) ncs_unit_checker_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_araddr(s_araddr),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
  .s_rvalid(s_rvalid), .s_rready(s_rready), .arr_start(arr_start), .arr_ready(arr_ready),
  .backdoor_ok(backdoor_ok), .security_state(security_state));

// [ncs_array_model.sv]
`timescale 1ns/1ns
`include "ncs_defines.vh"

module ncs_array_model (
  // clock and reset
  input wire sys_clk,
  input wire arst_n,
  // command from the unit
  input wire arr_start,
  input wire [7:0] arr_code,
  output logic arr_ready,
  output logic arr_done,
  output logic arr_blank,
  // bench control
  input wire [7:0] lat,
  input wire blank_cfg
);
  logic busy_reg, pend_reg, burst_reg;
  logic [7:0] cnt_reg;
  // one burst may queue behind a running burst
  assign arr_ready = !busy_reg || (burst_reg && !pend_reg);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {busy_reg, pend_reg, burst_reg, arr_done, arr_blank} <= 5'h00;
      cnt_reg <= 8'h00;
    end else begin
      arr_done <= 1'b0;
      arr_blank <= ~arr_blank;
      if (arr_start && busy_reg)
        pend_reg <= 1'b1;
      else if (arr_start) begin
        busy_reg <= 1'b1;
        burst_reg <= arr_code == `NCS_CMD_BURST_PROG;
        cnt_reg <= lat;
      end else if (busy_reg && cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
      else if (busy_reg && pend_reg) begin
        pend_reg <= 1'b0;
        cnt_reg <= lat;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        arr_done <= 1'b1;
        arr_blank <= blank_cfg;
      end
    end
  end
endmodule

// [ncs_nvm_command_status_unit_tb_top.sv]
`timescale 1ns/1ns
`include "ncs_defines.vh"

module ncs_nvm_command_status_unit_tb_top;
  logic sys_clk, arst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic arr_start, arr_ready, arr_done, arr_blank, stop_mode, bd_ok, blank_cfg;
  logic [7:0] s_awaddr, s_araddr, lat, arr_code, arr_data;
  logic [15:0] arr_addr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp, nv_sec, sec, r;
  logic [7:0] bad [4] = '{8'h00, 8'h21, 8'h46, 8'hFF};
  logic [7:0] good [6] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47};
  int fail_count, compares;

  ncs_nvm_command_status_unit ncs_nvm_command_status_unit_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .arr_start(arr_start), .arr_code(arr_code),
    .arr_addr(arr_addr), .arr_data(arr_data), .arr_ready(arr_ready), .arr_done(arr_done),
    .arr_blank(arr_blank), .stop_mode(stop_mode), .nv_security(nv_sec),
    .backdoor_ok(bd_ok), .security_state(sec));
  ncs_array_model ncs_array_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
    .arr_start(arr_start), .arr_code(arr_code), .arr_ready(arr_ready), .arr_done(arr_done),
    .arr_blank(arr_blank), .lat(lat), .blank_cfg(blank_cfg));

  // *****
  // checking and bus tasks
  // *****
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tmo;
    fail_count++;
    $display("unexpected at %0t: no answer", $time);
    end_of_test;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    bh = 0;
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1;
    s_wvalid <= 1;
    for (int k = 0; k < 60 && !bh; k++) begin
      #1;
      ah = s_awvalid && s_awready;
      wh = s_wvalid && s_wready;
      bh = s_bvalid === 1'b1;
      r = s_bresp;
      @(posedge sys_clk);
      if (ah) s_awvalid <= 0;
      if (wh) s_wvalid <= 0;
    end
    if (!bh) tmo;
  endtask
  task rd(input logic [7:0] a);
    logic ah, rh;
    rh = 0;
    s_araddr <= a;
    s_arvalid <= 1;
    for (int k = 0; k < 60 && !rh; k++) begin
      #1;
      ah = s_arvalid && s_arready;
      rh = s_rvalid === 1'b1;
      d = s_rdata;
      r = s_rresp;
      @(posedge sys_clk);
      if (ah) s_arvalid <= 0;
    end
    if (!rh) tmo;
  endtask
  task st(input logic [31:0] e);
    rd(`NCS_OFS_STATUS);
    chk(d, e);
  endtask
  task cmd(input logic [15:0] ad, input logic [7:0] c);
    wr(`NCS_OFS_ADDR, {16'h0000, ad});
    wr(`NCS_OFS_DATA, 32'h000000A5);
    wr(`NCS_OFS_CODE, {24'h000000, c});
    wr(`NCS_OFS_STATUS, 32'h00000080);
  endtask
  task idle;
    for (int k = 0; k < 100; k++) begin
      rd(`NCS_OFS_STATUS);
      if (d[6] === 1'b1) return;
    end
    tmo;
  endtask

  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end

  // *****
  // scenarios
  // *****
  initial begin
    {arst_n, s_awvalid, s_wvalid, s_arvalid, stop_mode, bd_ok, blank_cfg} = 7'h00;
    {s_bready, s_rready, s_wstrb, s_awaddr, s_araddr, s_wdata} = {2'h3, 4'hF, 48'h0};
    lat = 8'h03;
    nv_sec = 2'h3;
    fail_count = 0;
    compares = 0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1;
    @(posedge sys_clk);
    st(32'hC0);
    chk(sec, 2'h3);
    rd(8'h18);
    chk(r, `NCS_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h18, 32'h1);
    chk(r, `NCS_RESP_SLVERR);
    cmd(16'h2000, `NCS_CMD_BYTE_PROG);
    st(32'hD0);
    wr(`NCS_OFS_STATUS, 32'h4F);
    st(32'hD0);
    wr(`NCS_OFS_STATUS, 32'h10);
    st(32'hC0);
    wr(`NCS_OFS_DIVIDER, 32'h13);
    for (int i = 0; i < 4; i++) begin
      cmd(16'h2000, bad[i]);
      st(32'hD0);
      wr(`NCS_OFS_STATUS, 32'h10);
    end
    wr(`NCS_OFS_CODE, 32'h20);
    wr(`NCS_OFS_STATUS, 32'h80);
    st(32'hD0);
    wr(`NCS_OFS_STATUS, 32'h10);
    for (int i = 0; i < 6; i++) begin
      cmd(16'h2000, good[i]);
      idle;
      chk(arr_code, good[i]);
      chk(arr_addr, 16'h2000);
      chk(arr_data, 8'hA5);
      st(32'hC0);
    end
    blank_cfg <= 1;
    cmd(16'h2000, `NCS_CMD_BLANK);
    idle;
    st(32'hC4);
    chk(sec, `NCS_SEC_UNSECURED);
    arst_n <= 0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1;
    @(posedge sys_clk);
    st(32'hC0);
    chk(sec, 2'h3);
    wr(`NCS_OFS_DIVIDER, 32'h13);
    cmd(16'h1000, `NCS_CMD_BLANK);
    idle;
    st(32'hC4);
    chk(sec, 2'h3);
    bd_ok <= 1;
    @(posedge sys_clk);
    bd_ok <= 0;
    st(32'hC4);
    chk(sec, `NCS_SEC_UNSECURED);
    cmd(16'h3000, `NCS_CMD_BYTE_PROG);
    idle;
    st(32'hC0);
    wr(`NCS_OFS_PROT, 32'h00018000);
    cmd(16'h9000, `NCS_CMD_BYTE_PROG);
    st(32'hE0);
    wr(`NCS_OFS_STATUS, 32'h5F);
    st(32'hE0);
    wr(`NCS_OFS_STATUS, 32'h20);
    st(32'hC0);
    cmd(16'h1000, `NCS_CMD_MASS_ERASE);
    st(32'hE0);
    wr(`NCS_OFS_STATUS, 32'h20);
    lat <= 8'h28;
    for (int i = 0; i < 3; i++) cmd(16'h2000, `NCS_CMD_BURST_PROG);
    st(32'h00);
    idle;
    st(32'hC0);
    cmd(16'h2000, `NCS_CMD_BURST_PROG);
    stop_mode <= 1;
    @(posedge sys_clk);
    stop_mode <= 0;
    st(32'h90);
    wr(`NCS_OFS_STATUS, 32'h10);
    cmd(16'h2000, `NCS_CMD_BYTE_PROG);
    st(32'h90);
    wr(`NCS_OFS_STATUS, 32'h10);
    idle;
    st(32'hC0);
    end_of_test;
  end
endmodule
